/* File: hdl/acc_ctrl.sv */
/*
 * Channel and configuration control for a ten-bit successive approximation
 * converter: control registers, conversion clock divider, acquisition and
 * conversion sequencer, result formatting and a masked interrupt.
 * Assumes an analogue core that converts after a start pulse and answers
 * with a one-cycle done pulse carrying the ten-bit result.
 */
// Chosen here: the plain strobed port and the register addresses.
// Functional notes
// - Capture a ten-bit unsigned conversion result.
// - Twelve or sixteen inputs by package.
// - Channel field picks input in binary.
// - Codes twelve up absent on small package.
// - Busy bit reads running; software sets it.
// - Enable bit powers the converter.
// - Top two bits read zero.
// - Reference field selects rails or externals.
// - Port code sets analogue or digital pins.
// - Upper four pin settings need large package.
// - Implemented bits read/write, reset to zero.
// - Timing register plus high/low result registers.
// - Done loads result, clears busy, flags.
// - Justify bit picks right or left alignment.
// - Programmed acquisition periods precede conversion.
// - Reset turns converter off, aborts conversion.
`timescale 1ns/1ps
`default_nettype none

module acc_ctrl
    import acc_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1  // One for sixteen inputs, zero for twelve
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Register port
    input wire logic [ACC_ADDR_W-1:0] i_addr,
    input wire logic [ACC_DATA_W-1:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [ACC_DATA_W-1:0] o_rd_data,
    // Converter core
    output acc_core_req_t o_core_req,
    input wire logic i_core_done,
    input wire logic [ACC_RES_W-1:0] i_core_result,
    // Pins and status
    output logic [ACC_PIN_COUNT-1:0] o_pin_analog,
    output logic o_channel_absent,
    output logic o_irq
);

    // Register state
    logic [7:0] ctrl_reg;       // Channel and enable; busy lives in the sequencer
    logic [7:0] ref_reg;        // Reference and port configuration
    logic [7:0] tim_reg;        // Justify, acquisition and clock select
    logic [7:0] res_hi_reg;     // Result high byte
    logic [7:0] res_lo_reg;     // Result low byte
    logic [7:0] stat_reg;       // Sticky interrupt status
    logic [7:0] mask_reg;       // Interrupt mask
    acc_state_t state_reg;      // Sequencer state
    acc_state_t state_next;
    logic [ACC_DIV_W-1:0] div_cnt_reg;  // Conversion clock divider
    logic [ACC_ACQ_W-1:0] acq_cnt_reg;  // Remaining acquisition periods
    logic [ACC_ACQ_W-1:0] acq_cnt_next;
    logic start_reg;            // One-cycle start pulse to the core
    acc_core_req_t core_req_next;

    // Address decode
    wire wr_ctrl = i_wr_en && (i_addr == ACC_ADDR_CTRL);
    wire wr_ref = i_wr_en && (i_addr == ACC_ADDR_REF);
    wire wr_tim = i_wr_en && (i_addr == ACC_ADDR_TIM);
    wire wr_stat = i_wr_en && (i_addr == ACC_ADDR_STAT);
    wire wr_mask = i_wr_en && (i_addr == ACC_ADDR_MASK);

    // Field views
    wire conv_enable = ctrl_reg[ACC_CTRL_EN_BIT];
    wire [3:0] channel_sel = ctrl_reg[ACC_CTRL_CHS_LSB +: 4];
    wire [1:0] reference_select = ref_reg[ACC_REF_VREF_LSB +: 2];
    wire [3:0] pin_analog_config = ref_reg[ACC_REF_PCFG_LSB +: 4];
    wire result_justify = tim_reg[ACC_TIM_JUST_BIT];
    wire [2:0] acquisition_time_sel = tim_reg[ACC_TIM_ACQ_LSB +: 3];
    wire [2:0] conversion_clock_sel = tim_reg[ACC_TIM_CLK_LSB +: 3];
    wire busy = (state_reg != ACC_ST_IDLE);
    wire [7:0] status_byte = (ctrl_reg & ACC_CTRL_IMPL) | (8'(busy) << ACC_CTRL_GO_BIT);

    // Start request: a write of the busy bit with the enable bit set in the same write, while idle
    wire wr_enable = i_wr_data[ACC_CTRL_EN_BIT];
    wire start_req = wr_ctrl && i_wr_data[ACC_CTRL_GO_BIT] && wr_enable && !busy;
    // Clearing the enable bit kills whatever is in flight
    wire abort = wr_ctrl && !wr_enable;

    // Conversion clock ticks only while the sequencer runs
    wire [ACC_DIV_W-1:0] tad_div = acc_tad_div(conversion_clock_sel);
    wire tad_tick = busy && (div_cnt_reg == (tad_div - ACC_DIV_ONE));
    wire [ACC_ACQ_W-1:0] acq_len = acc_acq_len(acquisition_time_sel);

    // Result placement at the end of conversion
    wire done_evt = (state_reg == ACC_ST_CONV) && i_core_done && !abort;
    wire [7:0] res_hi_fmt = result_justify ? {6'h00, i_core_result[9:8]} : i_core_result[9:2];
    wire [7:0] res_lo_fmt = result_justify ? i_core_result[7:0] : {i_core_result[1:0], 6'h00};

    // Read mux; unmapped addresses read zero
    wire [7:0] rd_mux =
        (i_addr == ACC_ADDR_CTRL) ? status_byte :
        (i_addr == ACC_ADDR_REF) ? (ref_reg & ACC_REF_IMPL) :
        (i_addr == ACC_ADDR_TIM) ? (tim_reg & ACC_TIM_IMPL) :
        (i_addr == ACC_ADDR_RESH) ? res_hi_reg :
        (i_addr == ACC_ADDR_RESL) ? res_lo_reg :
        (i_addr == ACC_ADDR_STAT) ? stat_reg :
        (i_addr == ACC_ADDR_MASK) ? mask_reg : 8'h00;

    // Small package has no inputs twelve to fifteen; flag selection of them
    wire absent_next = !LARGE_PKG && (channel_sel >= 4'(ACC_SMALL_PINS));

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        acq_cnt_next = acq_cnt_reg;
        case (state_reg)
            ACC_ST_IDLE: begin
                if (start_req && (acq_len == ACC_ACQ_ZERO)) begin
                    state_next = ACC_ST_CONV;
                end else if (start_req) begin
                    state_next = ACC_ST_ACQ;
                    acq_cnt_next = acq_len;
                end
            end
            ACC_ST_ACQ: begin
                if (abort) begin
                    state_next = ACC_ST_IDLE;
                end else if (tad_tick && (acq_cnt_reg == ACC_ACQ_ONE)) begin
                    state_next = ACC_ST_CONV;
                    acq_cnt_next = ACC_ACQ_ZERO;
                end else if (tad_tick) begin
                    acq_cnt_next = ACC_ACQ_W'(acq_cnt_reg - ACC_ACQ_ONE);
                end
            end
            ACC_ST_CONV: begin
                if (abort || done_evt) begin
                    state_next = ACC_ST_IDLE;
                end
            end
            default: begin
                state_next = ACC_ST_IDLE;
            end
        endcase
    end

    // Core request; sampling runs whenever enabled and not converting
    always_comb begin
        core_req_next.enable = conv_enable;
        core_req_next.sample = conv_enable && (state_reg != ACC_ST_CONV);
        core_req_next.start = start_reg;
        core_req_next.vref = reference_select;
        core_req_next.channel = channel_sel;
    end

    // Control registers; only implemented bits are stored
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_reg <= ACC_REG_RESET;
            ref_reg <= ACC_REG_RESET;
            tim_reg <= ACC_REG_RESET;
            mask_reg <= ACC_REG_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= i_wr_data & ACC_CTRL_IMPL & ~(8'h01 << ACC_CTRL_GO_BIT);
            end
            if (wr_ref) begin
                ref_reg <= i_wr_data & ACC_REF_IMPL;
            end
            if (wr_tim) begin
                tim_reg <= i_wr_data & ACC_TIM_IMPL;
            end
            if (wr_mask) begin
                mask_reg <= i_wr_data & ACC_IRQ_IMPL;
            end
        end
    end

    // Sticky status: a done in the same cycle as a clear stays set
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stat_reg <= ACC_REG_RESET;
        end else begin
            stat_reg <= ((stat_reg & ~(wr_stat ? i_wr_data : 8'h00))
                | (8'(done_evt) << ACC_IRQ_DONE_BIT)) & ACC_IRQ_IMPL;
        end
    end

    // Result pair; not cleared by reset, so software must not trust it before a done
    always_ff @(posedge i_clk) begin
        if (done_evt) begin
            res_hi_reg <= res_hi_fmt;
            res_lo_reg <= res_lo_fmt;
        end
    end

    // Sequencer, divider and start pulse
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= ACC_ST_IDLE;
            acq_cnt_reg <= ACC_ACQ_ZERO;
            div_cnt_reg <= ACC_DIV_ZERO;
            start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            acq_cnt_reg <= acq_cnt_next;
            div_cnt_reg <= (!busy || tad_tick) ? ACC_DIV_ZERO : ACC_DIV_W'(div_cnt_reg + ACC_DIV_ONE);
            start_reg <= (state_next == ACC_ST_CONV) && (state_reg != ACC_ST_CONV);
        end
    end

    // Outputs from flops
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_data <= 8'h00;
            o_core_req <= '0;
            o_channel_absent <= 1'b0;
        end else begin
            o_rd_data <= i_rd_en ? rd_mux : 8'h00;
            o_core_req <= core_req_next;
            o_channel_absent <= absent_next;
        end
    end

    assign o_irq = |(stat_reg & mask_reg);

    // Pin mode decoder
    acc_pin_decode #(
        .LARGE_PKG(LARGE_PKG)
    ) u_pin_decode (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_pcfg(pin_analog_config),
        .o_analog(o_pin_analog)
    );

    // Busy bit on read mirrors the sequencer of the cycle before
    chk_busy_readback: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_rd_en && (i_addr == ACC_ADDR_CTRL)) |=> (o_rd_data[ACC_CTRL_GO_BIT] == $past(busy)))
        else $error("busy bit read back wrong");

    // Start with the converter off leaves the sequencer idle
    chk_start_when_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (wr_ctrl && i_wr_data[ACC_CTRL_GO_BIT] && !wr_enable) |=> (state_reg == ACC_ST_IDLE))
        else $error("start taken while disabled");

    // Done returns to idle and raises the flag
    chk_done_flags: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        done_evt |=> (!busy && stat_reg[ACC_IRQ_DONE_BIT]))
        else $error("done did not clear busy and set flag");

    // Unimplemented upper bits read zero
    chk_upper_bits_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_rd_en && ((i_addr == ACC_ADDR_CTRL) || (i_addr == ACC_ADDR_REF))) |=> (o_rd_data[7:6] == 2'b00))
        else $error("unimplemented bits read non-zero");

    // Disabling aborts any conversion at once; the core sees enable drop one edge later
    chk_disable_aborts: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        abort |=> !busy ##1 !o_core_req.enable)
        else $error("disable did not abort");

    // An accepted start shows as busy from the next edge
    chk_busy_on_start: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        start_req |=> busy)
        else $error("start did not raise busy");

    // Write one clears the flag when no done arrives in the same cycle
    chk_status_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (wr_stat && i_wr_data[ACC_IRQ_DONE_BIT] && !done_evt) |=> !stat_reg[ACC_IRQ_DONE_BIT])
        else $error("status flag not cleared");

    // Zero acquisition starts the core two edges after the write
    chk_acq_zero_start: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (start_req && (acq_len == ACC_ACQ_ZERO)) |=> (state_reg == ACC_ST_CONV) ##1 o_core_req.start)
        else $error("immediate conversion did not start");

    // Last acquisition period moves into conversion
    chk_acq_to_conv: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        ((state_reg == ACC_ST_ACQ) && tad_tick && (acq_cnt_reg == ACC_ACQ_ONE) && !abort)
        |=> (state_reg == ACC_ST_CONV) ##1 o_core_req.start)
        else $error("acquisition end did not start conversion");

    // Right justified result keeps the high byte upper bits clear
    chk_right_justify: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (done_evt && result_justify) |=> ((res_hi_reg[7:2] == 6'h00) && (res_lo_reg == $past(i_core_result[7:0]))))
        else $error("right justified result misplaced");

    // Left justified result keeps the low byte lower bits clear
    chk_left_justify: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (done_evt && !result_justify) |=> ((res_lo_reg[5:0] == 6'h00) && (res_hi_reg == $past(i_core_result[9:2]))))
        else $error("left justified result misplaced");

    // Channel written reaches the core two edges later
    chk_channel_drive: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        wr_ctrl |=> ##1 (o_core_req.channel == $past(i_wr_data[ACC_CTRL_CHS_LSB +: 4], 2)))
        else $error("channel select not driven");

endmodule // acc_ctrl

`default_nettype wire

/* File: hdl/acc_pkg.sv */
/*
 * Shared constants, types and helper functions for the converter channel and
 * configuration control block: register map, field positions, reset values,
 * conversion-clock divisors, acquisition lengths and the sequencer states.
 * Assumes a byte-wide register port and a single system clock.
 */
`default_nettype none

package acc_pkg;

    // Register port geometry
    localparam int ACC_ADDR_W = 4;
    localparam int ACC_DATA_W = 8;

    // Register indices on the plain register port
    localparam logic [3:0] ACC_ADDR_CTRL = 4'h0;   // conversion_control
    localparam logic [3:0] ACC_ADDR_REF = 4'h1;    // reference_port_config
    localparam logic [3:0] ACC_ADDR_TIM = 4'h2;    // timing_format_control
    localparam logic [3:0] ACC_ADDR_RESH = 4'h3;   // result_high
    localparam logic [3:0] ACC_ADDR_RESL = 4'h4;   // result_low
    localparam logic [3:0] ACC_ADDR_STAT = 4'h5;   // interrupt status, write one to clear
    localparam logic [3:0] ACC_ADDR_MASK = 4'h6;   // interrupt mask

    // Reset value and implemented-bit masks
    localparam logic [7:0] ACC_REG_RESET = 8'h00;
    localparam logic [7:0] ACC_CTRL_IMPL = 8'h3F;
    localparam logic [7:0] ACC_REF_IMPL = 8'h3F;
    localparam logic [7:0] ACC_TIM_IMPL = 8'hBF;
    localparam logic [7:0] ACC_IRQ_IMPL = 8'h01;

    // Field positions
    localparam int ACC_CTRL_EN_BIT = 0;
    localparam int ACC_CTRL_GO_BIT = 1;
    localparam int ACC_CTRL_CHS_LSB = 2;
    localparam int ACC_REF_VREF_LSB = 4;
    localparam int ACC_REF_PCFG_LSB = 0;
    localparam int ACC_TIM_JUST_BIT = 7;
    localparam int ACC_TIM_ACQ_LSB = 3;
    localparam int ACC_TIM_CLK_LSB = 0;
    localparam int ACC_IRQ_DONE_BIT = 0;

    // Converter geometry
    localparam int ACC_RES_W = 10;
    localparam int ACC_PIN_COUNT = 16;
    localparam int ACC_SMALL_PINS = 12;
    localparam logic [4:0] ACC_PCFG_LAST_SUM = 5'h0E;
    localparam logic [3:0] ACC_PCFG_ALL_ANALOG = 4'h0;
    localparam logic [3:0] ACC_PCFG_ALL_DIGITAL = 4'hF;

    // Divider and acquisition counter widths
    localparam int ACC_DIV_W = 7;
    localparam int ACC_ACQ_W = 5;
    localparam logic [6:0] ACC_DIV_ONE = 7'h01;
    localparam logic [6:0] ACC_DIV_ZERO = 7'h00;
    localparam logic [4:0] ACC_ACQ_ONE = 5'h01;
    localparam logic [4:0] ACC_ACQ_ZERO = 5'h00;

    // Conversion clock divisors, in system clocks per conversion-clock period
    localparam logic [6:0] ACC_DIV_2 = 7'h02;
    localparam logic [6:0] ACC_DIV_4 = 7'h04;
    localparam logic [6:0] ACC_DIV_8 = 7'h08;
    localparam logic [6:0] ACC_DIV_16 = 7'h10;
    localparam logic [6:0] ACC_DIV_32 = 7'h20;
    localparam logic [6:0] ACC_DIV_64 = 7'h40;
    localparam logic [6:0] ACC_DIV_RC = 7'h40;

    // Acquisition lengths in conversion-clock periods
    localparam logic [4:0] ACC_ACQ_0 = 5'h00;
    localparam logic [4:0] ACC_ACQ_2 = 5'h02;
    localparam logic [4:0] ACC_ACQ_4 = 5'h04;
    localparam logic [4:0] ACC_ACQ_6 = 5'h06;
    localparam logic [4:0] ACC_ACQ_8 = 5'h08;
    localparam logic [4:0] ACC_ACQ_12 = 5'h0C;
    localparam logic [4:0] ACC_ACQ_16 = 5'h10;
    localparam logic [4:0] ACC_ACQ_20 = 5'h14;

    // Sequencer states
    typedef enum logic [1:0] {
        ACC_ST_IDLE = 2'b00,
        ACC_ST_ACQ = 2'b01,
        ACC_ST_CONV = 2'b10
    } acc_state_t;

    // Request bundle towards the analogue converter core
    typedef struct packed {
        logic enable;
        logic sample;
        logic start;
        logic [1:0] vref;
        logic [3:0] channel;
    } acc_core_req_t;

    // Conversion-clock divisor from the clock select code
    function automatic logic [6:0] acc_tad_div(input logic [2:0] sel);
        logic [6:0] d;
        d = ACC_DIV_RC;
        case (sel)
            3'h0: d = ACC_DIV_2;
            3'h1: d = ACC_DIV_8;
            3'h2: d = ACC_DIV_32;
            3'h4: d = ACC_DIV_4;
            3'h5: d = ACC_DIV_16;
            3'h6: d = ACC_DIV_64;
            default: d = ACC_DIV_RC;
        endcase
        return d;
    endfunction

    // Acquisition length from the acquisition select code
    function automatic logic [4:0] acc_acq_len(input logic [2:0] sel);
        logic [4:0] n;
        n = ACC_ACQ_0;
        case (sel)
            3'h1: n = ACC_ACQ_2;
            3'h2: n = ACC_ACQ_4;
            3'h3: n = ACC_ACQ_6;
            3'h4: n = ACC_ACQ_8;
            3'h5: n = ACC_ACQ_12;
            3'h6: n = ACC_ACQ_16;
            3'h7: n = ACC_ACQ_20;
            default: n = ACC_ACQ_0;
        endcase
        return n;
    endfunction

endpackage

`default_nettype wire

/* File: hdl/acc_pin_decode.sv */
/*
 * Pin mode decoder: turns the port configuration code into one analogue
 * flag per input, registered.
 * Assumes the code comes from a register in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module acc_pin_decode
    import acc_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Configuration
    input wire logic [3:0] i_pcfg,
    // Pin modes, one means analogue
    output logic [ACC_PIN_COUNT-1:0] o_analog
);

    logic [ACC_PIN_COUNT-1:0] analog_next;  // Decoded modes before the flop

    // One decoder per input; code k leaves inputs whose index plus k is at most 14 analogue, code zero leaves every input analogue
    genvar gi;
    generate
        for (gi = 0; gi < ACC_PIN_COUNT; gi++) begin : g_pin
            wire pin_exists = LARGE_PKG || (gi < ACC_SMALL_PINS);
            wire [4:0] sum = 5'(gi) + {1'b0, i_pcfg};
            wire code_analog = (i_pcfg == ACC_PCFG_ALL_ANALOG) || (sum <= ACC_PCFG_LAST_SUM);
            assign analog_next[gi] = pin_exists && code_analog;
        end
    endgenerate

    // Registered so pad mode muxes see a clean level
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_analog <= '0;
        end else begin
            o_analog <= analog_next;
        end
    end

    // All digital code leaves no analogue input
    chk_all_digital_code: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_pcfg == ACC_PCFG_ALL_DIGITAL) |=> (o_analog == '0))
        else $error("all-digital code left an analogue input");

    // Absent inputs never turn analogue on the small package
    chk_small_pkg_pins: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !LARGE_PKG |-> (o_analog[ACC_PIN_COUNT-1:ACC_SMALL_PINS] == '0))
        else $error("absent input marked analogue");

endmodule // acc_pin_decode

`default_nettype wire

/* File: dv/acc_core_model.sv */
/*
 * Behavioural model of the analogue converter core: a start pulse begins a
 * conversion that ends with a one-cycle done pulse and a ten-bit result.
 * Assumes the request bundle of the package and the single system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module acc_core_model
    import acc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Request from the control block
    input wire acc_core_req_t i_req,
    // Test controls: result value and conversion length in cycles (1 or more)
    input wire logic [9:0] i_value,
    input wire logic [7:0] i_delay,
    // Answer
    output logic o_done,
    output logic [9:0] o_result
);
    logic [7:0] cnt_reg;  // Cycles left, zero when idle
    logic [9:0] last_reg; // Last result handed out

    // Converts for i_delay cycles; switching the converter off drops the job
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_reg <= 8'h00;
            o_done <= 1'b0;
            last_reg <= 10'h155;
        end else begin
            o_done <= 1'b0;
            if (!i_req.enable) begin
                cnt_reg <= 8'h00;
            end else if (i_req.start) begin
                cnt_reg <= i_delay;
            end else if (cnt_reg == 8'h01) begin
                cnt_reg <= 8'h00;
                o_done <= 1'b1;
                last_reg <= i_value;
            end else if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end

    // Outside the done cycle the result lines hold no stale copy of the value
    assign o_result = o_done ? last_reg : ~last_reg;
endmodule // acc_core_model

`default_nettype wire

/* File: dv/testbench.sv */
/*
 * Self-checking bench for the converter control block: registers, pin decode,
 * conversion sequencing, acquisition timing, interrupt and reset.
 * Assumes the core model in its own file and a 200 MHz system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import acc_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rd_data;
    acc_core_req_t req;
    logic done;
    logic [9:0] result;
    logic [15:0] pins;
    logic [15:0] s_pins; // Small package pin modes
    logic absent;
    logic s_absent;
    logic irq;
    logic [9:0] value = 10'h2A5;
    logic [7:0] delay = 8'h05;
    int fail_count = 0;
    int total_checks = 0;

    always #2.5 i_clk = ~i_clk;

    acc_ctrl #(.LARGE_PKG(1'b1)) uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(addr),
        .i_wr_data(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data), .o_core_req(req),
        .i_core_done(done), .i_core_result(result), .o_pin_analog(pins), .o_channel_absent(absent),
        .o_irq(irq));
    // Small package twin shares the bus; its core side stays idle
    acc_ctrl #(.LARGE_PKG(1'b0)) uut_small (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(addr),
        .i_wr_data(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(), .o_core_req(),
        .i_core_done(1'b0), .i_core_result(10'h000), .o_pin_analog(s_pins),
        .o_channel_absent(s_absent), .o_irq());
    acc_core_model core (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req), .i_value(value),
        .i_delay(delay), .o_done(done), .o_result(result));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One write cycle; returns at the edge that takes it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge i_clk);
        wr_en <= 1'b0;
    endtask

    // One read cycle; data is judged in the single cycle it stands
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge i_clk);
        rd_en <= 1'b0;
        #1 check(16'(rd_data), 16'(exp));
    endtask

    // Bounded wait for the interrupt line
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge i_clk);
            #1 n++;
        end
        check(16'(irq), 16'h0001);
    endtask

    task automatic t_reset();
        rd(ACC_ADDR_CTRL, 8'h00);
        rd(ACC_ADDR_REF, 8'h00);
        rd(ACC_ADDR_TIM, 8'h00);
        rd(ACC_ADDR_STAT, 8'h00);
        rd(ACC_ADDR_MASK, 8'h00);
        rd(4'hF, 8'h00);
    endtask

    // Every control, reference and timing field but busy written with ones, unimplemented bits must read back zero
    task automatic t_fields();
        wr(ACC_ADDR_CTRL, 8'hFD);
        wr(ACC_ADDR_REF, 8'hFF);
        rd(ACC_ADDR_CTRL, 8'h3D);
        rd(ACC_ADDR_REF, 8'h3F);
        wr(ACC_ADDR_TIM, 8'hFF);
        rd(ACC_ADDR_TIM, 8'hBF);
        check(16'(req.channel), 16'h000F);
        check(16'(req.enable), 16'h0001);
        check(16'(req.sample), 16'h0001);
        check(16'(absent), 16'h0000);
        check(16'(s_absent), 16'h0001);
    endtask

    // Each port code, with the reference codes cycled alongside
    task automatic t_pins();
        logic [15:0] exp;
        for (int k = 0; k < 16; k++) begin
            wr(ACC_ADDR_REF, 8'((k % 4) * 16 + k));
            repeat (3) @(posedge i_clk);
            exp = (k == 0) ? 16'hFFFF : 16'((32'h1 << (15 - k)) - 1);
            #1 check(pins, exp);
            check(s_pins, exp & 16'h0FFF);
            check(16'(req.vref), 16'(k % 4));
        end
    endtask

    // Start with the converter off is dropped
    task automatic t_disabled();
        wr(ACC_ADDR_CTRL, 8'h02);
        rd(ACC_ADDR_CTRL, 8'h00);
    endtask

    task automatic t_convert();
        wr(ACC_ADDR_MASK, 8'h01);
        wr(ACC_ADDR_TIM, 8'h80);
        wr(ACC_ADDR_CTRL, 8'h07);
        rd(ACC_ADDR_CTRL, 8'h07);
        wait_irq();
        rd(ACC_ADDR_CTRL, 8'h05);
        rd(ACC_ADDR_RESH, 8'h02);
        rd(ACC_ADDR_RESL, 8'hA5);
        rd(ACC_ADDR_STAT, 8'h01);
        wr(ACC_ADDR_STAT, 8'h01);
        #1 check(16'(irq), 16'h0000);
        wr(ACC_ADDR_TIM, 8'h00);
        wr(ACC_ADDR_MASK, 8'h00);
        wr(ACC_ADDR_CTRL, 8'h07);
        repeat (20) @(posedge i_clk);
        #1 check(16'(irq), 16'h0000);
        rd(ACC_ADDR_STAT, 8'h01);
        wr(ACC_ADDR_MASK, 8'h01);
        #1 check(16'(irq), 16'h0001);
        rd(ACC_ADDR_RESH, 8'hA9);
        rd(ACC_ADDR_RESL, 8'h40);
        wr(ACC_ADDR_STAT, 8'h01);
    endtask

    // Start pulse latency for every acquisition and clock code
    task automatic t_acq();
        int acq[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
        int div[8] = '{2, 8, 32, 64, 4, 16, 64, 64};
        int n;
        int base;
        base = 0;
        for (int i = 0; i < 8; i++) begin
            wr(ACC_ADDR_TIM, 8'(i * 9));
            wr(ACC_ADDR_CTRL, 8'h03);
            n = 0;
            #1;
            while (req.start !== 1'b1 && n < 2000) begin
                @(posedge i_clk);
                #1 n++;
            end
            if (i == 0)
                base = n;
            check(16'(n), 16'(base + acq[i] * div[i]));
            wait_irq();
            wr(ACC_ADDR_STAT, 8'h01);
        end
        check(16'(base), 16'h0001);
    endtask

    // Abort by clearing enable, then a reset in mid-conversion
    task automatic t_abort();
        delay <= 8'h32;
        wr(ACC_ADDR_TIM, 8'h00);
        wr(ACC_ADDR_CTRL, 8'h07);
        repeat (5) @(posedge i_clk);
        wr(ACC_ADDR_CTRL, 8'h04);
        rd(ACC_ADDR_CTRL, 8'h04);
        repeat (60) @(posedge i_clk);
        rd(ACC_ADDR_STAT, 8'h00);
        wr(ACC_ADDR_CTRL, 8'h07);
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b0;
        @(posedge i_clk);
        #1 check(16'(req), 16'h0000);
        @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(ACC_ADDR_CTRL, 8'h00);
        rd(ACC_ADDR_REF, 8'h00);
    endtask

    initial begin
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        #1 check(pins, 16'hFFFF);
        t_reset();
        t_fields();
        t_pins();
        t_disabled();
        t_convert();
        t_acq();
        t_abort();
        report_and_stop();
    end

    // Watchdog: the whole run needs about 3500 cycles
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end
endmodule // testbench

`default_nettype wire
